// ---- include/accr_regs.vh ----
`ifndef ACCR_REGS_VH
`define ACCR_REGS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ACCR_IDX_CAL_EN      10'h001
`define ACCR_IDX_CTRL_A      10'h002
`define ACCR_IDX_CTRL_B      10'h003

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACCR_RST_CAL_EN      16'h0000
`define ACCR_RST_CTRL_A      16'h0FF0
`define ACCR_RST_CTRL_B      16'h0164

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACCR_CAL_EN_LO       8
`define ACCR_CAL_EN_HI       11
`define ACCR_FP_SKIP_LO      12
`define ACCR_FP_SKIP_HI      13
`define ACCR_LP_SKIP_LO      14
`define ACCR_LP_SKIP_HI      15
`define ACCR_FF_SKIP_LO      0
`define ACCR_FF_SKIP_HI      3
`define ACCR_FP_HOLD_LO      4
`define ACCR_FP_HOLD_HI      7
`define ACCR_LP_HOLD_LO      8
`define ACCR_LP_HOLD_HI      11
`define ACCR_TIMEOUT_LO      12
`define ACCR_TIMEOUT_HI      13
`define ACCR_FORCED_BIT      14
`define ACCR_RESTART_BIT     15
`define ACCR_RECAL_LO        0
`define ACCR_RECAL_HI        7
`define ACCR_RATE_LO         8
`define ACCR_RATE_HI         13
`define ACCR_SLOW_LO         14
`define ACCR_SLOW_HI         15

// ----------------------------------------------------------------
// Counts and limits
// ----------------------------------------------------------------
`define ACCR_MAX_CODE        4'hB
`define ACCR_FP_HOLD_MUL     16
`define ACCR_LP_HOLD_MUL     4
`define ACCR_TIMEOUT_BASE    5

`endif

// ---- logic/accr_ctrl_regs.v ----
// Notes on behaviour
// - Full-power skip code 0..3 skips 3, 7, 15 or 31 samples.
// - Low-power skip code 0..3 skips 0, 1, 2 or 3 samples.
// - Fast-filter skip N admits one sequence after N skipped, max 11.
// - Full power holds calibration for count times 16 sequences.
// - Low power holds calibration for count times 4 sequences.
// - Power drops after 1.25 to 2.00 times the full-power hold time.
// - The forced-calibration bit recalibrates every stage while set.
// - Writing one to restart resets the sequence to stage 0, self-clears.
// - Recalibration level is sixteen times its field, reset 0x64.
// - Detection rate is sixteen times its field, reset one.
// - Slow-filter update setting resets to zero and is passed out.
// - A sequence has stage-count plus one stages, at most twelve.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "accr_regs.vh"

module accr_ctrl_regs (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ce,
  input  wire [9:0]  addr,
  input  wire [15:0] wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  input  wire [3:0]  stage_count,
  input  wire        stage_done,
  input  wire        low_power,
  input  wire        prox_active,
  output reg  [15:0] rd_data_q,
  output reg  [4:0]  fp_skip_q,
  output reg  [1:0]  lp_skip_q,
  output reg  [11:0] calib_run_q,
  output reg  [11:0] recal_level_q,
  output reg  [9:0]  detect_rate_q,
  output reg  [1:0]  slow_filter_q,
  output reg         restart_q,
  output reg  [3:0]  stage_q,
  output reg         ff_admit_q,
  output reg         calib_hold_q,
  output reg         power_drop_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Limits a four-bit code to the largest legal value
  function [3:0] accr_clamp;
    input [3:0] code;
    begin
      if (code > `ACCR_MAX_CODE) begin
        accr_clamp = `ACCR_MAX_CODE;
      end else begin
        accr_clamp = code;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg        rst_meta_q;
  reg        rst_n_q;

  // Asserts at once, releases after two edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [15:0] cal_en_q;
  reg [15:0] ctrl_a_q;
  reg [15:0] ctrl_b_q;

  wire       wr_cal_en;
  wire       wr_ctrl_a;
  wire       wr_ctrl_b;

  assign wr_cal_en = wr_en && (addr == `ACCR_IDX_CAL_EN);
  assign wr_ctrl_a = wr_en && (addr == `ACCR_IDX_CTRL_A);
  assign wr_ctrl_b = wr_en && (addr == `ACCR_IDX_CTRL_B);

  // Field views
  wire [1:0] fp_code;
  wire [1:0] lp_code;
  wire [3:0] ff_skip;
  wire [3:0] fp_hold;
  wire [3:0] lp_hold;
  wire [1:0] tmo_code;
  wire       forced;

  assign fp_code  = cal_en_q[`ACCR_FP_SKIP_HI:`ACCR_FP_SKIP_LO];
  assign lp_code  = cal_en_q[`ACCR_LP_SKIP_HI:`ACCR_LP_SKIP_LO];
  assign ff_skip  = accr_clamp(ctrl_a_q[`ACCR_FF_SKIP_HI:`ACCR_FF_SKIP_LO]);
  assign fp_hold  = ctrl_a_q[`ACCR_FP_HOLD_HI:`ACCR_FP_HOLD_LO];
  assign lp_hold  = ctrl_a_q[`ACCR_LP_HOLD_HI:`ACCR_LP_HOLD_LO];
  assign tmo_code = ctrl_a_q[`ACCR_TIMEOUT_HI:`ACCR_TIMEOUT_LO];
  assign forced   = ctrl_a_q[`ACCR_FORCED_BIT];

  // Software writes; restart bit never stored, it only pulses
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cal_en_q  <= `ACCR_RST_CAL_EN;
      ctrl_a_q  <= `ACCR_RST_CTRL_A;
      ctrl_b_q  <= `ACCR_RST_CTRL_B;
      restart_q <= 1'b0;
    end else if (ce) begin
      if (wr_cal_en) begin
        cal_en_q <= wr_data;
      end
      if (wr_ctrl_a) begin
        ctrl_a_q <= {1'b0, wr_data[14:0]};
      end
      if (wr_ctrl_b) begin
        ctrl_b_q <= wr_data;
      end
      // One-cycle restart pulse, then self-clears
      restart_q <= wr_ctrl_a && wr_data[`ACCR_RESTART_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  // Data one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data_q <= 16'h0000;
    end else if (ce) begin
      rd_data_q <= 16'h0000;
      if (rd_en) begin
        case (addr)
          `ACCR_IDX_CAL_EN: rd_data_q <= cal_en_q;
          `ACCR_IDX_CTRL_A: rd_data_q <= {restart_q, ctrl_a_q[14:0]};
          `ACCR_IDX_CTRL_B: rd_data_q <= ctrl_b_q;
          default:          rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  reg  [4:0] fp_skip_d;
  wire [3:0] cal_hi;

  assign cal_hi = cal_en_q[`ACCR_CAL_EN_HI:`ACCR_CAL_EN_LO];

  // Full-power skip decode
  always @* begin
    case (fp_code)
      2'b00:   fp_skip_d = 5'h03;
      2'b01:   fp_skip_d = 5'h07;
      2'b10:   fp_skip_d = 5'h0F;
      2'b11:   fp_skip_d = 5'h1F;
      default: fp_skip_d = 5'h03;
    endcase
  end

  // Registered copies of the decoded settings
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fp_skip_q     <= 5'h03;
      lp_skip_q     <= 2'h0;
      calib_run_q   <= 12'h000;
      recal_level_q <= 12'h640;
      detect_rate_q <= 10'h010;
      slow_filter_q <= 2'h0;
    end else if (ce) begin
      fp_skip_q     <= fp_skip_d;
      lp_skip_q     <= lp_code;
      // Forced calibration overrides every stage enable
      calib_run_q   <= {cal_hi, cal_en_q[7:0]} | {12{forced}};
      recal_level_q <= {ctrl_b_q[`ACCR_RECAL_HI:`ACCR_RECAL_LO],
                        4'h0};
      detect_rate_q <= {ctrl_b_q[`ACCR_RATE_HI:`ACCR_RATE_LO],
                        4'h0};
      slow_filter_q <= ctrl_b_q[`ACCR_SLOW_HI:`ACCR_SLOW_LO];
    end
  end

  // ----------------------------------------------------------------
  // Stage sequencer
  // ----------------------------------------------------------------
  wire [3:0] last_stage;
  wire       seq_end;

  assign last_stage = accr_clamp(stage_count);
  assign seq_end    = stage_done && (stage_q >= last_stage);

  // Walks stages 0..last; restart returns to stage 0
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stage_q <= 4'h0;
    end else if (ce) begin
      if (restart_q) begin
        stage_q <= 4'h0;
      end else if (seq_end) begin
        stage_q <= 4'h0;
      end else if (stage_done) begin
        stage_q <= stage_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fast-filter sequence skipping
  // ----------------------------------------------------------------
  reg  [3:0] ff_cnt_q;

  // Admits one sequence once N have been skipped
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ff_cnt_q   <= 4'h0;
      ff_admit_q <= 1'b0;
    end else if (ce) begin
      ff_admit_q <= 1'b0;
      if (restart_q) begin
        ff_cnt_q <= 4'h0;
      end else if (seq_end) begin
        if (ff_cnt_q >= ff_skip) begin
          ff_cnt_q   <= 4'h0;
          ff_admit_q <= 1'b1;
        end else begin
          ff_cnt_q <= ff_cnt_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration hold and power-drop timeout
  // ----------------------------------------------------------------
  reg  [7:0] hold_q;
  reg  [7:0] hold_d;
  reg  [8:0] idle_q;
  reg  [8:0] idle_d;
  wire [7:0] fp_len;
  wire [7:0] lp_len;
  wire [8:0] tmo_len;
  wire [3:0] tmo_mul;

  // Hold lengths in sequences of the current mode
  assign fp_len  = {fp_hold, 4'h0};
  assign lp_len  = {2'b00, lp_hold, 2'b00};
  // Timeout = fp_hold * 16 * (5 + code) / 4 = fp_hold * 4 * (5 + code)
  assign tmo_mul = {2'b00, tmo_code} + 4'h5;
  // Product fits seven bits (15 * 8); two low zeros multiply by four
  assign tmo_len = {({3'h0, fp_hold} * {3'h0, tmo_mul}),
                    2'b00};

  // Next hold and idle counts, stepped per finished sequence
  always @* begin
    hold_d = hold_q;
    idle_d = idle_q;
    if (seq_end) begin
      if (prox_active) begin
        hold_d = low_power ? lp_len : fp_len;
        idle_d = 9'h000;
      end else begin
        if (hold_q != 8'h00) begin
          hold_d = hold_q - 8'h01;
        end
        if (!low_power && (idle_q < tmo_len)) begin
          idle_d = idle_q + 9'h001;
        end
      end
    end
    if (low_power) begin
      idle_d = 9'h000;
    end
  end

  // Hold and idle state, registered flags
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_q       <= 8'h00;
      idle_q       <= 9'h000;
      calib_hold_q <= 1'b0;
      power_drop_q <= 1'b0;
    end else if (ce) begin
      hold_q       <= hold_d;
      idle_q       <= idle_d;
      calib_hold_q <= (hold_d != 8'h00) && !forced;
      power_drop_q <= !low_power && (idle_d >= tmo_len);
    end
  end

endmodule

// ---- verification/accr_ctrl_regs_properties.sv ----
`timescale 1ns/100ps
module accr_ctrl_regs_properties (
  input wire        clk,
  input wire        reset_n,
  input wire        ce,
  input wire [9:0]  addr,
  input wire [15:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [3:0]  stage_count,
  input wire        stage_done,
  input wire        low_power,
  input wire        prox_active,
  input wire [15:0] rd_data_q,
  input wire [4:0]  fp_skip_q,
  input wire [1:0]  lp_skip_q,
  input wire [11:0] calib_run_q,
  input wire [11:0] recal_level_q,
  input wire [9:0]  detect_rate_q,
  input wire [1:0]  slow_filter_q,
  input wire        restart_q,
  input wire [3:0]  stage_q,
  input wire        ff_admit_q,
  input wire        calib_hold_q,
  input wire        power_drop_q
);
  // Accepted writes per index and the clamped last stage
  wire       w1  = ce & wr_en & (addr == 10'h001);
  wire       w2  = ce & wr_en & (addr == 10'h002);
  wire       w3  = ce & wr_en & (addr == 10'h003);
  wire [3:0] lim = (stage_count > 4'hb) ? 4'hb : stage_count;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Decoded outputs follow a write by two edges: store, then decode
  a_fp_skip_decode: assert property (w1 |-> ##2
    fp_skip_q == (5'h4 << $past(wr_data[13:12], 2)) - 5'h1)
    else $error("fp skip");
  a_lp_skip_copy: assert property (w1 |-> ##2
    lp_skip_q == $past(wr_data[15:14], 2)) else $error("lp skip");
  a_calib_forced: assert property (w2 && wr_data[14] |-> ##2
    calib_run_q == 12'hfff) else $error("forced calibration");
  a_restart_pulse: assert property (restart_q |->
    $past(w2 && wr_data[15]) ##1 stage_q == 4'h0) else $error("restart");
  a_recal_scale: assert property (w3 |-> ##2
    recal_level_q == {$past(wr_data[7:0], 2), 4'h0})
    else $error("recal level");
  a_rate_scale: assert property (w3 |-> ##2
    detect_rate_q == {$past(wr_data[13:8], 2), 4'h0}) else $error("rate");
  a_slow_copy: assert property (w3 |-> ##2
    slow_filter_q == $past(wr_data[15:14], 2)) else $error("slow filter");
  a_stage_wrap: assert property (ce && stage_done && !restart_q
    && stage_q >= lim |=> stage_q == 4'h0) else $error("stage wrap");
endmodule

// ---- verification/accr_ctrl_regs_tb_top.sv ----
`timescale 1ns/100ps
module accr_ctrl_regs_tb_top;
  reg         clk = 0, reset_n = 0, ce = 1, wr_en = 0, rd_en = 0;
  reg         stage_done = 0, low_power = 0, prox_active = 0;
  reg  [9:0]  addr = 0;
  reg  [15:0] wr_data = 0, d;
  reg  [3:0]  stage_count = 0;
  wire [15:0] rd_data_q;
  wire [11:0] calib_run_q, recal_level_q;
  wire [9:0]  detect_rate_q;
  wire [4:0]  fp_skip_q;
  wire [3:0]  stage_q;
  wire [1:0]  lp_skip_q, slow_filter_q;
  wire        restart_q, ff_admit_q, calib_hold_q, power_drop_q;
  integer     seed = 69603, mismatches = 0, tests_run = 0;
  integer     i, c, n, admits = 0;

  accr_ctrl_regs uut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .stage_count(stage_count), .stage_done(stage_done),
    .low_power(low_power), .prox_active(prox_active),
    .rd_data_q(rd_data_q), .fp_skip_q(fp_skip_q), .lp_skip_q(lp_skip_q),
    .calib_run_q(calib_run_q), .recal_level_q(recal_level_q),
    .detect_rate_q(detect_rate_q), .slow_filter_q(slow_filter_q),
    .restart_q(restart_q), .stage_q(stage_q), .ff_admit_q(ff_admit_q),
    .calib_hold_q(calib_hold_q), .power_drop_q(power_drop_q));

  // Clock and admit counter
  always #10 clk = ~clk;
  always @(posedge clk) if (ff_admit_q) admits = admits + 1;

  task chk(input string nm, input [15:0] s, input [15:0] e); begin
    tests_run = tests_run + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  end endtask

  task wr(input [9:0] a, input [15:0] v); begin
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  end endtask

  task rd(input [9:0] a, input [15:0] e); begin
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_data_q", rd_data_q, e);
  end endtask

  // Complete m stages, one per cycle, then let the flags settle
  task seq(input integer m, input p); begin
    repeat (2) @(posedge clk);
    if (m > 0) begin
      stage_done <= 1'b1;
      prox_active <= p;
      repeat (m) @(posedge clk);
      stage_done <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
  end endtask

  function [4:0] fpx(input [1:0] cd);
    fpx = (cd == 0) ? 3 : (cd == 1) ? 7 : (cd == 2) ? 15 : 31;
  endfunction

  task close_out; begin
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end endtask

  initial begin
    #1000000;
    mismatches = mismatches + 1;
    close_out;
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("fp_skip_q", fp_skip_q, 16'h0003);
    chk("detect_rate_q", detect_rate_q, 16'h0010);
    rd(10'h001, 16'h0000);
    rd(10'h002, 16'h0ff0);
    rd(10'h003, 16'h0164);
    wr(10'h3ff, 16'hffff);
    rd(10'h3ff, 16'h0000);
    rd(10'h001, 16'h0000);
    for (i = 0; i < 16; i = i + 1) begin
      d = $random(seed);
      wr(10'h001, d);
      @(posedge clk) #1;
      chk("fp_skip_q", fp_skip_q, fpx(d[13:12]));
      chk("lp_skip_q", lp_skip_q, d[15:14]);
      chk("calib_run_q", calib_run_q, d[11:0]);
      wr(10'h003, d);
      @(posedge clk) #1;
      chk("recal_level_q", recal_level_q, {d[7:0], 4'h0});
      chk("detect_rate_q", detect_rate_q, {d[13:8], 4'h0});
      chk("slow_filter_q", slow_filter_q, d[15:14]);
      wr(10'h002, d & 16'h3fff);
      rd(10'h002, d & 16'h3fff);
      rd(10'h001, d);
      @(posedge clk) stage_count <= d[3:0];
      seq(5, 1'b0);
    end
    // Clock enable low freezes every register but the reset synchroniser, writes included
    @(posedge clk) ce <= 1'b0;
    wr(10'h003, 16'h0000);
    @(posedge clk) ce <= 1'b1;
    rd(10'h003, d);
    chk("recal_level_q", recal_level_q, {d[7:0], 4'h0});
    @(posedge clk) stage_count <= 4'h0;
    // Fast-filter skip codes including one above the largest legal one
    for (c = 0; c < 4; c = c + 1) begin
      n = (c == 0) ? 0 : (c == 1) ? 3 : (c == 2) ? 11 : 15;
      wr(10'h002, 16'h8000 | n);
      chk("restart_q", restart_q, 16'h0001);
      @(posedge clk) #1;
      chk("stage_q", stage_q, 16'h0000);
      admits = 0;
      seq(3 * ((n > 11 ? 11 : n) + 1), 1'b0);
      chk("admits", admits, 16'h0003);
    end
    // Hold and timeout figures for every timeout code
    for (c = 0; c < 4; c = c + 1) begin
      wr(10'h002, {2'b00, c[1:0], 8'h11, 4'h0});
      seq(1, 1'b1);
      seq(14, 1'b0);
      chk("calib_hold_q", calib_hold_q, 16'h0001);
      seq(4, 1'b0);
      chk("calib_hold_q", calib_hold_q, 16'h0000);
      seq(4 * c, 1'b0);
      chk("power_drop_q", power_drop_q, 16'h0000);
      seq(4, 1'b0);
      chk("power_drop_q", power_drop_q, 16'h0001);
      @(posedge clk) low_power <= 1'b1;
      seq(1, 1'b1);
      chk("power_drop_q", power_drop_q, 16'h0000);
      seq(2, 1'b0);
      chk("calib_hold_q", calib_hold_q, 16'h0001);
      seq(4, 1'b0);
      chk("calib_hold_q", calib_hold_q, 16'h0000);
      @(posedge clk) low_power <= 1'b0;
    end
    // Second reset in mid-run restores the reset values
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("recal_level_q", recal_level_q, 16'h0640);
    rd(10'h002, 16'h0ff0);
    rd(10'h001, 16'h0000);
    wr(10'h002, 16'h4011);
    @(posedge clk) #1;
    chk("calib_run_q", calib_run_q, 16'h0fff);
    seq(1, 1'b1);
    chk("calib_hold_q", calib_hold_q, 16'h0000);
    close_out;
  end
endmodule

bind accr_ctrl_regs accr_ctrl_regs_properties chk_i (.clk(clk),
  .reset_n(reset_n), .ce(ce), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .stage_count(stage_count),
  .stage_done(stage_done), .low_power(low_power),
  .prox_active(prox_active), .rd_data_q(rd_data_q),
  .fp_skip_q(fp_skip_q), .lp_skip_q(lp_skip_q),
  .calib_run_q(calib_run_q), .recal_level_q(recal_level_q),
  .detect_rate_q(detect_rate_q), .slow_filter_q(slow_filter_q),
  .restart_q(restart_q), .stage_q(stage_q), .ff_admit_q(ff_admit_q),
  .calib_hold_q(calib_hold_q), .power_drop_q(power_drop_q));
